// ---- rtl/mfc_fault_config.sv ----
// Purpose: fault threshold registers, decode and fault supervision
// Assumes: detector inputs come from logic on mclk
// Notes: thresholds are captured on eval_tick
// Notes on behaviour
// - desync fault after configured loss count
// - no-motor sense voltage threshold from code
// - overvoltage latches or clears by policy
// - upper supply limit from code
// - undervoltage latches or clears by policy
// - lower supply limit from code
// - retry attempt cap from code
// - lock fault below minimum speed
// - speed jump fault above ratio limit
// - target speed zero below duty floor
// - speed jump check only when enabled
// - desync check only when enabled
// - no-motor check only when enabled
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
module mfc_fault_config (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // detector inputs
    input wire logic eval_tick,
    input wire logic sync_lost,
    input wire logic [9:0] supply_dv,
    input wire logic [8:0] sense_level,
    input wire logic [15:0] elec_speed,
    input wire logic [9:0] duty_level,
    // decoded thresholds
    output logic [3:0] sync_loss_limit,
    output logic [8:0] absent_load_current_level,
    output logic [9:0] supply_upper_limit,
    output logic [9:0] supply_lower_limit,
    output logic [4:0] retry_limit,
    output logic [5:0] lock_min_speed,
    output logic [3:0] speed_jump_ratio,
    output logic [4:0] idle_duty_floor,
    output logic overvoltage_clear_policy,
    output logic undervoltage_clear_policy,
    output logic speed_anomaly_check_on,
    output logic desync_check_on,
    output logic absent_load_check_on,
    // fault state
    output logic [mfc_pkg::ST_W-1:0] fault_flags,
    output logic target_zero,
    output logic irq
);
    import mfc_pkg::*;

    logic [31:0] fault_limits_second;
    logic [31:0] pin_setup_first;
    logic [31:0] pin_setup_second;
    logic [31:0] chip_setup_word;
    logic [ST_W-1:0] irq_mask;
    logic [ST_W-1:0] next_flags;
    logic [ST_W-1:0] set_ev;
    logic [ST_W-1:0] w1c;
    logic [3:0] desync_cnt;
    logic [15:0] prev_speed;
    logic [19:0] jump_bound;
    logic over_now;
    logic under_now;
    logic desync_hit;

    // ==========================================================
    // register writes
    always_ff @(posedge mclk) begin
        if (srst) begin
            fault_limits_second <= RST_FAULT_LIMITS_SECOND;
            pin_setup_first <= RST_PIN_SETUP_FIRST;
            pin_setup_second <= RST_PIN_SETUP_SECOND;
            chip_setup_word <= RST_CHIP_SETUP_WORD;
            irq_mask <= RST_IRQ;
        end else if (reg_wr) begin
            case (reg_addr)
                OFS_FAULT_LIMITS_SECOND: begin
                    fault_limits_second <= reg_wdata;
                end
                OFS_PIN_SETUP_FIRST: begin
                    pin_setup_first <= reg_wdata & WMASK_PIN_SETUP_FIRST;
                end
                OFS_PIN_SETUP_SECOND: begin
                    pin_setup_second <= reg_wdata & WMASK_PIN_SETUP_SECOND;
                end
                OFS_CHIP_SETUP_WORD: begin
                    chip_setup_word <= reg_wdata;
                end
                OFS_IRQ_MASK: begin
                    irq_mask <= reg_wdata[ST_W-1:0];
                end
                default: begin
                    // unlisted offsets are left untouched
                    irq_mask <= irq_mask;
                end
            endcase
        end
    end

    // ==========================================================
    // register reads, data one cycle after strobe
    always_ff @(posedge mclk) begin
        if (srst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                OFS_FAULT_LIMITS_SECOND: reg_rdata <= fault_limits_second;
                OFS_PIN_SETUP_FIRST: reg_rdata <= pin_setup_first;
                OFS_PIN_SETUP_SECOND: reg_rdata <= pin_setup_second;
                OFS_CHIP_SETUP_WORD: reg_rdata <= chip_setup_word;
                OFS_IRQ_STATUS: reg_rdata <= {26'h000_0000, fault_flags};
                OFS_IRQ_MASK: reg_rdata <= {26'h000_0000, irq_mask};
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // ==========================================================
    // field decode, captured at each evaluation
    mfc_lut #(.IW(3), .W(4), .TABLE(TBL_SYNC_TIMES)) u_sync (
        .mclk(mclk),
        .srst(srst),
        .load(eval_tick),
        .code(fault_limits_second[POS_SYNC_TIMES +: 3]),
        .value(sync_loss_limit)
    );

    mfc_lut #(.IW(3), .W(9), .TABLE(TBL_ABSENT_LEVEL)) u_absent (
        .mclk(mclk),
        .srst(srst),
        .load(eval_tick),
        .code(fault_limits_second[POS_ABSENT_LOAD_LEVEL +: 3]),
        .value(absent_load_current_level)
    );

    mfc_lut #(.IW(3), .W(10), .TABLE(TBL_SUPPLY_UPPER)) u_upper (
        .mclk(mclk),
        .srst(srst),
        .load(eval_tick),
        .code(fault_limits_second[POS_SUPPLY_UPPER +: 3]),
        .value(supply_upper_limit)
    );

    mfc_lut #(.IW(3), .W(10), .TABLE(TBL_SUPPLY_LOWER)) u_lower (
        .mclk(mclk),
        .srst(srst),
        .load(eval_tick),
        .code(fault_limits_second[POS_SUPPLY_LOWER +: 3]),
        .value(supply_lower_limit)
    );

    mfc_lut #(.IW(3), .W(5), .TABLE(TBL_RETRY)) u_retry (
        .mclk(mclk),
        .srst(srst),
        .load(eval_tick),
        .code(fault_limits_second[POS_RETRY_TIMES +: 3]),
        .value(retry_limit)
    );

    mfc_lut #(.IW(3), .W(6), .TABLE(TBL_MIN_SPEED)) u_speed (
        .mclk(mclk),
        .srst(srst),
        .load(eval_tick),
        .code(fault_limits_second[POS_MIN_SPEED +: 3]),
        .value(lock_min_speed)
    );

    mfc_lut #(.IW(2), .W(4), .TABLE(TBL_JUMP_RATIO)) u_ratio (
        .mclk(mclk),
        .srst(srst),
        .load(eval_tick),
        .code(fault_limits_second[POS_JUMP_RATIO +: 2]),
        .value(speed_jump_ratio)
    );

    mfc_lut #(.IW(2), .W(5), .TABLE(TBL_DUTY_FLOOR)) u_duty (
        .mclk(mclk),
        .srst(srst),
        .load(eval_tick),
        .code(fault_limits_second[POS_DUTY_FLOOR +: 2]),
        .value(idle_duty_floor)
    );

    // ==========================================================
    // mode and enable bits, captured at each evaluation
    always_ff @(posedge mclk) begin
        if (srst) begin
            overvoltage_clear_policy <= 1'b0;
            undervoltage_clear_policy <= 1'b0;
            speed_anomaly_check_on <= 1'b0;
            desync_check_on <= 1'b0;
            absent_load_check_on <= 1'b0;
        end else if (eval_tick) begin
            overvoltage_clear_policy <= fault_limits_second[POS_OV_POLICY];
            undervoltage_clear_policy <= fault_limits_second[POS_UV_POLICY];
            speed_anomaly_check_on <= fault_limits_second[POS_SPEED_ANOMALY_ON];
            desync_check_on <= fault_limits_second[POS_DESYNC_ON];
            absent_load_check_on <= fault_limits_second[POS_ABSENT_LOAD_ON];
        end
    end

    // ==========================================================
    // sync loss counter
    assign desync_hit = desync_check_on && sync_lost && ((desync_cnt + 4'h1) >= sync_loss_limit);

    always_ff @(posedge mclk) begin
        if (srst) begin
            desync_cnt <= 4'h0;
        end else if (!desync_check_on) begin
            desync_cnt <= 4'h0;
        end else if (desync_hit) begin
            desync_cnt <= 4'h0;
        end else if (sync_lost) begin
            desync_cnt <= desync_cnt + 4'h1;
        end
    end

    // ==========================================================
    // supply and speed comparisons
    assign over_now = (supply_upper_limit != 10'h000) && (supply_dv > supply_upper_limit);
    assign under_now = (supply_lower_limit != 10'h000) && (supply_dv < supply_lower_limit);
    assign jump_bound = prev_speed * speed_jump_ratio;

    always_ff @(posedge mclk) begin
        if (srst) begin
            prev_speed <= 16'h0000;
        end else if (eval_tick) begin
            prev_speed <= elec_speed;
        end
    end

    // ==========================================================
    // fault events
    always_comb begin
        set_ev = '0;
        set_ev[ST_DESYNC] = desync_hit;
        set_ev[ST_OVER] = eval_tick && over_now;
        set_ev[ST_UNDER] = eval_tick && under_now;
        set_ev[ST_ABSENT] = eval_tick && absent_load_check_on
            && (sense_level < absent_load_current_level);
        set_ev[ST_SLOW] = eval_tick && ({10'h000, lock_min_speed} > elec_speed);
        set_ev[ST_JUMP] = eval_tick && speed_anomaly_check_on && (prev_speed != 16'h0000)
            && ({4'h0, elec_speed} > jump_bound);
    end

    // ==========================================================
    // sticky status, write one to clear, set wins
    always_comb begin
        w1c = '0;
        if (reg_wr && (reg_addr == OFS_IRQ_STATUS)) begin
            w1c = reg_wdata[ST_W-1:0];
        end
        if (eval_tick && overvoltage_clear_policy && !over_now) begin
            w1c[ST_OVER] = 1'b1;
        end
        if (eval_tick && undervoltage_clear_policy && !under_now) begin
            w1c[ST_UNDER] = 1'b1;
        end
        next_flags = (fault_flags & ~w1c) | set_ev;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            fault_flags <= RST_IRQ;
        end else begin
            fault_flags <= next_flags;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_flags & irq_mask);
        end
    end

    // ==========================================================
    // zero target speed
    always_ff @(posedge mclk) begin
        if (srst) begin
            target_zero <= 1'b1;
        end else begin
            target_zero <= duty_level < {5'h00, idle_duty_floor};
        end
    end

endmodule

// ---- rtl/mfc_lut.sv ----
// Purpose: small code-to-value table lookup with registered output
// Assumes: load is a one-cycle capture strobe
// Notes: entry for code 0 sits in the low bits of the table
`timescale 1ns/1ps
module mfc_lut #(
    parameter int IW = 3,
    parameter int W = 4,
    parameter logic [(W << IW)-1:0] TABLE = '0
) (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // code in, value out
    input wire logic load,
    input wire logic [IW-1:0] code,
    output logic [W-1:0] value
);

    // ==========================================================
    // held value
    always_ff @(posedge mclk) begin
        if (srst) begin
            value <= TABLE[W-1:0];
        end else if (load) begin
            value <= TABLE[code*W +: W];
        end
    end

endmodule

// ---- rtl/mfc_pkg.sv ----
// Purpose: shared constants for the motor fault configuration block
// Assumes: registers are reached at their printed offsets over a plain port
// Notes: decoded values use fixed units, see each table
package mfc_pkg;

    // ==========================================================
    // register offsets
    localparam logic [7:0] OFS_FAULT_LIMITS_SECOND = 8'h94;
    localparam logic [7:0] OFS_PIN_SETUP_FIRST = 8'hA4;
    localparam logic [7:0] OFS_PIN_SETUP_SECOND = 8'hA6;
    localparam logic [7:0] OFS_CHIP_SETUP_WORD = 8'hA8;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'hB0;
    localparam logic [7:0] OFS_IRQ_MASK = 8'hB4;

    // ==========================================================
    // reset values
    localparam logic [31:0] RST_FAULT_LIMITS_SECOND = 32'h0000_0000;
    localparam logic [31:0] RST_PIN_SETUP_FIRST = 32'h0000_0000;
    localparam logic [31:0] RST_PIN_SETUP_SECOND = 32'h0000_0000;
    localparam logic [31:0] RST_CHIP_SETUP_WORD = 32'h0000_0000;
    localparam logic [5:0] RST_IRQ = 6'h00;

    // ==========================================================
    // writable bits; reserved bits read zero
    localparam logic [31:0] WMASK_PIN_SETUP_FIRST = 32'hFFFF_FFFE;
    localparam logic [31:0] WMASK_PIN_SETUP_SECOND = 32'hE80F_E000;

    // ==========================================================
    // field positions in fault_limits_second
    localparam int POS_SPEED_ANOMALY_ON = 30;
    localparam int POS_DESYNC_ON = 29;
    localparam int POS_ABSENT_LOAD_ON = 28;
    localparam int POS_SYNC_TIMES = 21;
    localparam int POS_ABSENT_LOAD_LEVEL = 18;
    localparam int POS_OV_POLICY = 17;
    localparam int POS_SUPPLY_UPPER = 14;
    localparam int POS_UV_POLICY = 13;
    localparam int POS_SUPPLY_LOWER = 10;
    localparam int POS_RETRY_TIMES = 7;
    localparam int POS_MIN_SPEED = 4;
    localparam int POS_JUMP_RATIO = 2;
    localparam int POS_DUTY_FLOOR = 0;

    // ==========================================================
    // status and mask bit positions
    localparam int ST_DESYNC = 0;
    localparam int ST_OVER = 1;
    localparam int ST_UNDER = 2;
    localparam int ST_ABSENT = 3;
    localparam int ST_SLOW = 4;
    localparam int ST_JUMP = 5;
    localparam int ST_W = 6;

    // ==========================================================
    // decode tables, code 0 in the low slice
    // sync losses before fault
    localparam logic [31:0] TBL_SYNC_TIMES = {4'h9, 4'h8, 4'h7, 4'h6, 4'h5, 4'h4, 4'h3, 4'h2};
    // sense voltage in 0.1 mV
    localparam logic [71:0] TBL_ABSENT_LEVEL = {9'h190, 9'h12C, 9'h0FA, 9'h0C8,
        9'h07D, 9'h064, 9'h04B, 9'h032};
    // supply in 0.1 V, zero is no limit
    localparam logic [79:0] TBL_SUPPLY_UPPER = {10'h258, 10'h1F4, 10'h190, 10'h15E,
        10'h12C, 10'h0FA, 10'h0C8, 10'h000};
    localparam logic [79:0] TBL_SUPPLY_LOWER = {10'h096, 10'h078, 10'h064, 10'h05A,
        10'h050, 10'h046, 10'h03C, 10'h000};
    // retry attempts, zero is unlimited
    localparam logic [39:0] TBL_RETRY = {5'h14, 5'h0F, 5'h0A, 5'h07, 5'h05, 5'h03, 5'h02, 5'h00};
    // speed in 0.5 Hz
    localparam logic [47:0] TBL_MIN_SPEED = {6'h32, 6'h1E, 6'h14, 6'h0A, 6'h06, 6'h04, 6'h02, 6'h01};
    // speed ratio
    localparam logic [15:0] TBL_JUMP_RATIO = {4'h8, 4'h6, 4'h4, 4'h2};
    // duty in 0.1 percent
    localparam logic [19:0] TBL_DUTY_FLOOR = {5'h19, 5'h14, 5'h0F, 5'h0A};

endpackage

// ---- verif/mfc_fault_config_checker.sv ----
// Purpose: port assertions for the fault configuration block
// Assumes: one clock, synchronous reset
// Notes: bound to every instance of the block
`timescale 1ns/1ps
module mfc_fault_config_checker (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // register port
    input wire logic reg_wr,
    // detector inputs
    input wire logic eval_tick,
    input wire logic [9:0] supply_dv,
    input wire logic [8:0] sense_level,
    input wire logic [15:0] elec_speed,
    input wire logic [9:0] duty_level,
    // decoded outputs
    input wire logic [3:0] sync_loss_limit,
    input wire logic [8:0] absent_load_current_level,
    input wire logic [9:0] supply_upper_limit,
    input wire logic [9:0] supply_lower_limit,
    input wire logic [5:0] lock_min_speed,
    input wire logic [3:0] speed_jump_ratio,
    input wire logic [4:0] idle_duty_floor,
    input wire logic overvoltage_clear_policy,
    input wire logic undervoltage_clear_policy,
    input wire logic absent_load_check_on,
    // fault state
    input wire logic [mfc_pkg::ST_W-1:0] fault_flags,
    input wire logic target_zero
);
    import mfc_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);

    // ==========================================================
    // assertions
    a_loss_range: assert property (eval_tick |=> sync_loss_limit inside {[4'h2:4'h9]})
        else $error("loss limit out of range");
    a_absent_set: assert property (eval_tick && absent_load_check_on &&
        sense_level < absent_load_current_level |=> fault_flags[ST_ABSENT])
        else $error("absent load flag missed");
    a_over_latch: assert property (fault_flags[ST_OVER] && !overvoltage_clear_policy &&
        !reg_wr |=> fault_flags[ST_OVER]) else $error("latched over flag dropped");
    a_over_set: assert property (eval_tick && supply_upper_limit != 10'h000 &&
        supply_dv > supply_upper_limit |=> fault_flags[ST_OVER]) else $error("over flag missed");
    a_under_clear: assert property (fault_flags[ST_UNDER] && undervoltage_clear_policy &&
        eval_tick && supply_dv >= supply_lower_limit |=> !fault_flags[ST_UNDER])
        else $error("under flag not auto cleared");
    a_under_set: assert property (eval_tick && supply_lower_limit != 10'h000 &&
        supply_dv < supply_lower_limit |=> fault_flags[ST_UNDER]) else $error("under flag missed");
    a_slow_set: assert property (eval_tick && elec_speed < 16'(lock_min_speed)
        |=> fault_flags[ST_SLOW]) else $error("slow flag missed");
    a_ratio_codes: assert property (eval_tick |=> speed_jump_ratio inside {4'h2, 4'h4, 4'h6, 4'h8})
        else $error("bad ratio value");
    a_zero_duty: assert property (!$past(srst) |->
        target_zero == ($past(duty_level) < 10'($past(idle_duty_floor)))) else $error("target zero wrong");
    a_hold_between: assert property (!eval_tick |=> $stable(sync_loss_limit) &&
        $stable(speed_jump_ratio) && $stable(supply_upper_limit)) else $error("threshold moved");

    // ==========================================================
    // covers
    c_over: cover property (eval_tick ##1 fault_flags[ST_OVER]);
    c_desync: cover property ($rose(fault_flags[ST_DESYNC]));
    c_under_clear: cover property ($fell(fault_flags[ST_UNDER]));
endmodule

bind mfc_fault_config mfc_fault_config_checker u_chk (.mclk, .srst, .reg_wr, .eval_tick, .supply_dv,
    .sense_level, .elec_speed, .duty_level, .sync_loss_limit, .absent_load_current_level,
    .supply_upper_limit, .supply_lower_limit, .lock_min_speed, .speed_jump_ratio, .idle_duty_floor,
    .overvoltage_clear_policy, .undervoltage_clear_policy, .absent_load_check_on, .fault_flags,
    .target_zero);

// ---- verif/mfc_fault_config_test.sv ----
// Purpose: directed bench for the fault configuration block
// Assumes: flags at B0 (write one to clear), mask at B4
// Notes: elec_speed kept high so the slow flag stays quiet until t_jump drops it to zero
`timescale 1ns/1ps
module mfc_fault_config_test;
    logic mclk, srst, reg_wr, reg_rd, eval_tick, sync_lost, target_zero, irq;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [9:0] supply_dv, duty_level, supply_upper_limit, supply_lower_limit;
    logic [8:0] sense_level, absent_load_current_level;
    logic [15:0] elec_speed;
    logic [3:0] sync_loss_limit, speed_jump_ratio;
    logic [4:0] retry_limit, idle_duty_floor;
    logic [5:0] lock_min_speed, fault_flags;
    int n_fail, n_tests;

    mfc_fault_config dut (.mclk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .eval_tick, .sync_lost, .supply_dv, .sense_level, .elec_speed, .duty_level,
        .sync_loss_limit, .absent_load_current_level, .supply_upper_limit, .supply_lower_limit,
        .retry_limit, .lock_min_speed, .speed_jump_ratio, .idle_duty_floor,
        .overvoltage_clear_policy(), .undervoltage_clear_policy(), .speed_anomaly_check_on(),
        .desync_check_on(), .absent_load_check_on(), .fault_flags, .target_zero, .irq);

    always #5 mclk = ~mclk;

    // ==========================================================
    // helpers
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    task automatic tick;
        @(posedge mclk);
        eval_tick <= 1'b1;
        @(posedge mclk);
        eval_tick <= 1'b0;
        #1;
    endtask
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge mclk);
            sync_lost <= 1'b1;
            @(posedge mclk);
            sync_lost <= 1'b0;
        end
        repeat (2) @(posedge mclk);
        #1;
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // ==========================================================
    // scenarios
    task automatic t_regs;
        rd(8'h94, 32'h0);
        wr(8'hA4, 32'hFFFFFFFF);
        rd(8'hA4, 32'hFFFFFFFE);
        wr(8'hA6, 32'hFFFFFFFF);
        rd(8'hA6, 32'hE80FE000);
        wr(8'h90, 32'hFFFFFFFF);
        rd(8'h90, 32'h0);
        $display("register test done");
    endtask
    task automatic t_decode;
        int lv[8] = '{50, 75, 100, 125, 200, 250, 300, 400};
        int up[8] = '{0, 200, 250, 300, 350, 400, 500, 600};
        int lo[8] = '{0, 60, 70, 80, 90, 100, 120, 150};
        int rt[8] = '{0, 2, 3, 5, 7, 10, 15, 20};
        int sp[8] = '{1, 2, 4, 6, 10, 20, 30, 50};
        logic [2:0] k;
        logic [31:0] w;
        for (int i = 0; i < 8; i++) begin
            k = 3'(i);
            w = {8'h10, k, k, 1'b0, k, 1'b0, k, k, k, k[1:0], k[1:0]};
            wr(8'h94, w);
            chk(sync_loss_limit, (i == 0) ? 2 : i + 1);
            rd(8'h94, w);
            tick;
            tick;
            chk(sync_loss_limit, i + 2);
            chk(absent_load_current_level, lv[i]);
            chk(supply_upper_limit, up[i]);
            chk(supply_lower_limit, lo[i]);
            chk(retry_limit, rt[i]);
            chk(lock_min_speed, sp[i]);
            chk(speed_jump_ratio, 2 * (i % 4) + 2);
            chk(idle_duty_floor, 10 + 5 * (i % 4));
            chk(target_zero, i % 4 != 0);
            chk(fault_flags[3], i >= 4);
        end
        $display("decode test done");
    endtask
    task automatic t_supply;
        wr(8'h94, 32'h00006400);
        tick;
        // flags left by the old settings are cleared once the new ones hold
        wr(8'hB0, 32'h3F);
        wr(8'hB4, 32'h0);
        supply_dv <= 10'd201;
        tick;
        chk(fault_flags[1], 1);
        chk(irq, 0);
        wr(8'hB4, 32'h02);
        @(posedge mclk);
        #1 chk(irq, 1);
        supply_dv <= 10'd100;
        tick;
        chk(fault_flags[1], 1);
        wr(8'hB0, 32'h02);
        @(posedge mclk);
        #1 chk(irq, 0);
        rd(8'hB0, 32'h0);
        supply_dv <= 10'd59;
        tick;
        chk(fault_flags[2], 1);
        supply_dv <= 10'd100;
        tick;
        chk(fault_flags[2], 0);
        $display("supply test done");
    endtask
    task automatic t_desync;
        wr(8'h94, 32'h20200000);
        tick;
        pulse(2);
        chk(fault_flags[0], 0);
        pulse(1);
        chk(fault_flags[0], 1);
        wr(8'hB0, 32'h01);
        wr(8'h94, 32'h00200000);
        tick;
        pulse(4);
        chk(fault_flags[0], 0);
        $display("desync test done");
    endtask
    task automatic t_jump;
        wr(8'hB0, 32'h3F);
        wr(8'h94, 32'h40000000);
        elec_speed <= 16'd100;
        tick;
        tick;
        elec_speed <= 16'd201;
        tick;
        chk(fault_flags[5], 1);
        elec_speed <= 16'd0;
        tick;
        chk(fault_flags[4], 1);
        $display("speed test done");
    endtask

    // ==========================================================
    // main sequence and watchdog
    initial begin
        mclk = 0; srst = 1; reg_wr = 0; reg_rd = 0; reg_addr = 0; reg_wdata = 0;
        eval_tick = 0; sync_lost = 0; supply_dv = 100; sense_level = 9'h0C0;
        elec_speed = 16'h0100; duty_level = 12; n_fail = 0; n_tests = 0;
        repeat (4) @(posedge mclk);
        srst <= 1'b0;
        t_regs;
        t_decode;
        t_supply;
        t_desync;
        t_jump;
        stop_test;
    end
    initial begin
        repeat (5000) @(posedge mclk);
        n_fail++;
        stop_test;
    end
endmodule
